/* hdl/fbcl_defs.vh */
`ifndef FBCL_DEFS_VH
`define FBCL_DEFS_VH
// ==========================================
// clock and timing
`define FBCL_CLK_MHZ 100
`define FBCL_POR_MS 16
`define FBCL_POR_CYCLES (`FBCL_POR_MS * 1000 * `FBCL_CLK_MHZ)
`define FBCL_MASTER_POR_FACTOR 4
`define FBCL_INIT_WAIT_US 50
`define FBCL_INIT_WAIT_CYCLES (`FBCL_INIT_WAIT_US * `FBCL_CLK_MHZ)
`define FBCL_SAMPLE_DELAY 2
`define FBCL_CONFIG_CLOCK_HALF_SLOW 64
`define FBCL_RATE_FACTOR 8
`define FBCL_CONFIG_CLOCK_HALF_FAST (`FBCL_CONFIG_CLOCK_HALF_SLOW / `FBCL_RATE_FACTOR)
// ==========================================
// stream format
`define FBCL_PREAMBLE 4'h2
`define FBCL_LENGTH_BITS 24
`define FBCL_FRAME_BITS 32
`define FBCL_FRAME_COUNT 4
`define FBCL_RATE_BIT_POS 2
`define FBCL_NUM_FRAMES 16
`define FBCL_ADDR_WIDTH 18
// ==========================================
// mode line codes
`define FBCL_MODE_MASTER_SERIAL 3'h0
`define FBCL_MODE_MASTER_PAR 3'h6
`define FBCL_MODE_SLAVE_SERIAL 3'h7
`endif

/* hdl/fbcl_pair_buffer.v */
`timescale 1ns/100ps
`include "fbcl_defs.vh"
// ==========================================
// small fifo between stream decoder and frame sink
module fbcl_pair_buffer #(
	parameter WIDTH = 1,
	parameter DEPTH = 2,
	parameter PTR_W = 1
) (
	input wire clock,
	input wire reset,
	input wire clock_enable,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	localparam [31:0] LAST_W = DEPTH - 1;
	localparam [31:0] FULL_W = DEPTH;
	localparam [PTR_W-1:0] LAST = LAST_W[PTR_W-1:0];
	localparam [PTR_W:0] FULL = FULL_W[PTR_W:0];
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr;
	reg [PTR_W-1:0] rd_ptr;
	reg [PTR_W:0] count;
	wire push;
	wire pop;
	assign in_ready = count != FULL;
	assign out_valid = count != {(PTR_W+1){1'b0}};
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always @(posedge clock) begin
		if (reset) begin
			wr_ptr <= {PTR_W{1'b0}};
			rd_ptr <= {PTR_W{1'b0}};
			count <= {(PTR_W+1){1'b0}};
		end else if (clock_enable) begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= (wr_ptr == LAST) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= (rd_ptr == LAST) ? {PTR_W{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

/* hdl/fbcl_loader.v */
`timescale 1ns/100ps
`include "fbcl_defs.vh"
// What this block does
// - stream opens with preamble 0010 then a 24-bit config clock count
// - after preamble and count, pass-through stays high until own frames end
// - after own frames, later start bits and data are passed through
// - count config clocks after memory clear; start up when count hits length
// - after power check, 16 ms power-on delay, four times longer in master
// - during delay keep clearing frames on internal clock; program request holds clear_addr at 0
// - after each pass test delay and program; if idle, clear once more
// - from power-up low/init/done outputs low and high-during-config high
// - release open-drain init only after the final clearing pass
// - master waits 50 to 250 us before taking init as inactive
// - two clocks after init seen high, sample three mode lines
// - master: a bit early in first frame can raise clock rate eightfold
// - each frame is a low start bit then its configuration bits
// - program low holds clear_addr at 0; on release clear one full pass, then the final pass, then configure
// - program low forces init output low
// - init held low externally: wait after clear, then sample mode
// - slave serial: pass-through changes on falling edge after sampling
// - master parallel: drive memory address, capture byte as address moves
// - parallel byte leaves lsb first, bit 0 out 1.5 periods after capture
module fbcl_loader #(
	parameter POR_CYCLES = `FBCL_POR_CYCLES,
	parameter INIT_WAIT = `FBCL_INIT_WAIT_CYCLES,
	parameter NUM_FRAMES = `FBCL_NUM_FRAMES,
	parameter FRAME_BITS = `FBCL_FRAME_BITS,
	parameter FRAME_COUNT = `FBCL_FRAME_COUNT,
	parameter CONFIG_CLOCK_HALF_SLOW = `FBCL_CONFIG_CLOCK_HALF_SLOW,
	parameter CONFIG_CLOCK_HALF_FAST = `FBCL_CONFIG_CLOCK_HALF_FAST,
	parameter ADDR_WIDTH = `FBCL_ADDR_WIDTH
) (
	input wire clock,
	input wire reset,
	input wire clock_enable,
	input wire program_n,
	input wire init_in,
	output wire init_out,
	output wire init_oe,
	input wire [2:0] mode_lines,
	input wire config_clock_in,
	output reg config_clock_out,
	output wire config_clock_oe,
	input wire serial_in,
	input wire [7:0] byte_in,
	output reg [ADDR_WIDTH-1:0] memory_address,
	output reg pass_out,
	output reg high_during_config,
	output reg low_during_config_n,
	output reg config_done,
	output reg config_overrun,
	output wire frame_valid,
	input wire frame_ready,
	output wire frame_data
);
	// ==========================================
	// states
	localparam [3:0] ST_CLEAR = 4'h0;
	localparam [3:0] ST_FINAL = 4'h1;
	localparam [3:0] ST_WAIT_INIT = 4'h2;
	localparam [3:0] ST_INIT_DELAY = 4'h3;
	localparam [3:0] ST_SAMPLE = 4'h4;
	localparam [3:0] ST_HUNT = 4'h5;
	localparam [3:0] ST_LENGTH = 4'h6;
	localparam [3:0] ST_FRAMES = 4'h7;
	localparam [3:0] ST_PASS = 4'h8;
	localparam [3:0] ST_DONE = 4'h9;
	localparam [31:0] FAST_LOAD = CONFIG_CLOCK_HALF_FAST - 1;
	localparam [31:0] SLOW_LOAD = CONFIG_CLOCK_HALF_SLOW - 1;
	// ==========================================
	// pin synchronisers: stage one feeds stage two only
	reg [14:0] pins_meta;
	reg [14:0] pins_sync;
	reg config_clock_prev;
	always @(posedge clock) begin
		if (reset) begin
			pins_meta <= 15'h0000;
			pins_sync <= 15'h0000;
			config_clock_prev <= 1'b0;
		end else if (clock_enable) begin
			pins_meta <= {program_n, init_in, mode_lines, config_clock_in,
				serial_in, byte_in};
			pins_sync <= pins_meta;
			config_clock_prev <= pins_sync[9];
		end
	end
	wire prog_s = pins_sync[14];
	wire init_s = pins_sync[13];
	wire [2:0] mode_s = pins_sync[12:10];
	wire config_clock_s = pins_sync[9];
	wire serial_s = pins_sync[8];
	wire [7:0] byte_s = pins_sync[7:0];
	// ==========================================
	// state registers
	reg [3:0] state;
	reg [31:0] por_count;
	reg [31:0] wait_count;
	reg [15:0] clear_addr;
	reg [2:0] mode_latched;
	reg fast_rate;
	reg [3:0] pre_shift;
	reg [4:0] len_index;
	reg [23:0] length_value;
	reg [23:0] clk_count;
	reg in_frame;
	reg [15:0] bit_index;
	reg [15:0] frame_index;
	reg pending_bit;
	reg [7:0] byte_shift;
	reg [2:0] byte_index;
	reg have_byte;
	reg [15:0] div_count;
	reg push_valid;
	reg push_data;
	wire buf_ready;
	wire master = !mode_latched[0];
	wire parallel = mode_latched == `FBCL_MODE_MASTER_PAR;
	wire link_active = (state >= ST_HUNT) && (state <= ST_PASS);
	wire fall_window = link_active || (state == ST_DONE);
	wire por_busy = por_count != 32'h0000_0000;
	wire last_frame = clear_addr == NUM_FRAMES - 1;
	// ==========================================
	// init pin: open drain, held low through clearing or program request
	assign init_out = 1'b0;
	assign init_oe = (state == ST_CLEAR) || (state == ST_FINAL) || !prog_s;
	// ==========================================
	// config clock: master divides the internal clock, slave samples the pin
	assign config_clock_oe = master && link_active;
	wire master_tick = link_active && master && buf_ready &&
		(div_count == 16'h0000);
	wire config_clock_rise = master ? (master_tick && !config_clock_out) :
		(link_active && config_clock_s && !config_clock_prev);
	// slave fall still counts in done: the last bit must leave on it
	wire config_clock_fall = master ? (master_tick && config_clock_out) :
		(fall_window && !config_clock_s && config_clock_prev);
	always @(posedge clock) begin
		if (reset) begin
			div_count <= 16'h0000;
			config_clock_out <= 1'b0;
		end else if (clock_enable) begin
			if (!link_active || !master) begin
				div_count <= 16'h0000;
				config_clock_out <= 1'b0;
			end else if (buf_ready) begin
				// a full buffer freezes the clock, so no frame bit is lost
				if (div_count == 16'h0000) begin
					config_clock_out <= !config_clock_out;
					div_count <= fast_rate ? FAST_LOAD[15:0] :
						SLOW_LOAD[15:0];
				end else begin
					div_count <= div_count - 16'h0001;
				end
			end
		end
	end
	// ==========================================
	// bit source: serial pin or parallel byte shifter
	wire bit_ok = parallel ? have_byte : 1'b1;
	wire cur_bit = parallel ? byte_shift[0] : serial_s;
	always @(posedge clock) begin
		if (reset) begin
			byte_shift <= 8'h00;
			byte_index <= 3'h0;
			have_byte <= 1'b0;
			memory_address <= {ADDR_WIDTH{1'b0}};
		end else if (clock_enable) begin
			if (!link_active) begin
				have_byte <= 1'b0;
				byte_index <= 3'h0;
				memory_address <= {ADDR_WIDTH{1'b0}};
			end else if (parallel && config_clock_rise) begin
				if (!have_byte || byte_index == 3'h7) begin
					byte_shift <= byte_s;
					memory_address <= memory_address + 1'b1;
					have_byte <= 1'b1;
					byte_index <= 3'h0;
				end else begin
					byte_shift <= {1'b0, byte_shift[7:1]};
					byte_index <= byte_index + 3'h1;
				end
			end
		end
	end
	// ==========================================
	// sequencer
	always @(posedge clock) begin
		if (reset) begin
			state <= ST_CLEAR;
			por_count <= 32'h0000_0001;
			wait_count <= 32'h0000_0000;
			clear_addr <= 16'h0000;
			mode_latched <= `FBCL_MODE_SLAVE_SERIAL;
			fast_rate <= 1'b0;
			pre_shift <= 4'hF;
			len_index <= 5'h00;
			length_value <= 24'h000000;
			clk_count <= 24'h000000;
			in_frame <= 1'b0;
			bit_index <= 16'h0000;
			frame_index <= 16'h0000;
			pending_bit <= 1'b1;
			pass_out <= 1'b1;
			push_valid <= 1'b0;
			push_data <= 1'b0;
			config_overrun <= 1'b0;
			high_during_config <= 1'b1;
			low_during_config_n <= 1'b0;
			config_done <= 1'b0;
		end else if (clock_enable) begin
			push_valid <= 1'b0;
			// power-on delay runs once from reset, longer in master mode
			if (por_busy) begin
				if (por_count >= (mode_s[0] ? POR_CYCLES :
					POR_CYCLES * `FBCL_MASTER_POR_FACTOR))
					por_count <= 32'h0000_0000;
				else
					por_count <= por_count + 32'h0000_0001;
			end
			if (config_clock_fall)
				pass_out <= pending_bit;
			if (!prog_s) begin
				state <= ST_CLEAR;
				clear_addr <= 16'h0000;
				fast_rate <= 1'b0;
				high_during_config <= 1'b1;
				low_during_config_n <= 1'b0;
				config_done <= 1'b0;
				pass_out <= 1'b1;
				pending_bit <= 1'b1;
			end else begin
				case (state)
				ST_CLEAR: begin
					clear_addr <= last_frame ? 16'h0000 : clear_addr + 16'h0001;
					if (last_frame && !por_busy)
						state <= ST_FINAL;
				end
				ST_FINAL: begin
					clear_addr <= last_frame ? 16'h0000 : clear_addr + 16'h0001;
					if (last_frame)
						state <= ST_WAIT_INIT;
				end
				ST_WAIT_INIT: begin
					wait_count <= 32'h0000_0000;
					if (init_s)
						state <= mode_s[0] ? ST_SAMPLE : ST_INIT_DELAY;
				end
				ST_INIT_DELAY: begin
					if (!init_s) begin
						state <= ST_WAIT_INIT;
					end else if (wait_count >= INIT_WAIT - 1) begin
						wait_count <= 32'h0000_0000;
						state <= ST_SAMPLE;
					end else begin
						wait_count <= wait_count + 32'h0000_0001;
					end
				end
				ST_SAMPLE: begin
					if (wait_count >= `FBCL_SAMPLE_DELAY - 1) begin
						mode_latched <= mode_s;
						state <= ST_HUNT;
						pre_shift <= 4'hF;
						clk_count <= 24'h000000;
						len_index <= 5'h00;
					end else begin
						wait_count <= wait_count + 32'h0000_0001;
					end
				end
				ST_HUNT, ST_LENGTH, ST_FRAMES, ST_PASS: begin
					if (config_clock_rise) begin
						clk_count <= clk_count + 24'h000001;
						if ((state == ST_FRAMES || state == ST_PASS) &&
							clk_count + 24'h000001 == length_value) begin
							state <= ST_DONE;
							config_done <= 1'b1;
							high_during_config <= 1'b0;
							low_during_config_n <= 1'b1;
						end
					end
					if (config_clock_rise && bit_ok) begin
						case (state)
						ST_HUNT: begin
							pending_bit <= cur_bit;
							pre_shift <= {pre_shift[2:0], cur_bit};
							if ({pre_shift[2:0], cur_bit} == `FBCL_PREAMBLE)
								state <= ST_LENGTH;
						end
						ST_LENGTH: begin
							pending_bit <= cur_bit;
							length_value <= {length_value[22:0], cur_bit};
							len_index <= len_index + 5'h01;
							if (len_index == `FBCL_LENGTH_BITS - 1) begin
								state <= ST_FRAMES;
								in_frame <= 1'b0;
								frame_index <= 16'h0000;
							end
						end
						ST_FRAMES: begin
							pending_bit <= 1'b1;
							if (!in_frame) begin
								if (!cur_bit) begin
									in_frame <= 1'b1;
									bit_index <= 16'h0000;
								end
							end else begin
								push_valid <= 1'b1;
								push_data <= cur_bit;
								if (!buf_ready)
									config_overrun <= 1'b1;
								if (master && frame_index == 16'h0000 &&
									bit_index == `FBCL_RATE_BIT_POS)
									fast_rate <= cur_bit;
								bit_index <= bit_index + 16'h0001;
								if (bit_index == FRAME_BITS - 1) begin
									in_frame <= 1'b0;
									frame_index <= frame_index + 16'h0001;
									if (frame_index == FRAME_COUNT - 1)
										state <= ST_PASS;
								end
							end
						end
						default: begin
							pending_bit <= cur_bit;
						end
						endcase
					end
				end
				ST_DONE: begin
					if (config_clock_fall)
						pending_bit <= 1'b1;
				end
				default: begin
					state <= ST_CLEAR;
				end
				endcase
			end
		end
	end
	// ==========================================
	// frame bit buffer; slave clock cannot be held, so a full buffer
	// there sets the overrun flag instead
	fbcl_pair_buffer #(
		.WIDTH(1),
		.DEPTH(2),
		.PTR_W(1)
	) frame_buffer (
		.clock(clock),
		.reset(reset),
		.clock_enable(clock_enable),
		.in_valid(push_valid),
		.in_ready(buf_ready),
		.in_data(push_data),
		.out_valid(frame_valid),
		.out_ready(frame_ready),
		.out_data(frame_data)
	);
endmodule

/* testbench/fbcl_loader_props.sv */
`timescale 1ns/100ps
// ==========================================
// port checker for the loader
module fbcl_loader_props #(
	parameter NUM_FRAMES = 16,
	parameter ADDR_WIDTH = 18
) (
	input logic clock,
	input logic reset,
	input logic program_n,
	input logic init_oe,
	input logic config_clock_in,
	input logic config_clock_out,
	input logic config_clock_oe,
	input logic [ADDR_WIDTH-1:0] memory_address,
	input logic pass_out,
	input logic high_during_config,
	input logic low_during_config_n,
	input logic config_done,
	input logic frame_valid,
	input logic frame_ready,
	input logic frame_data
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// ==========================================
	// assertions
	AST_RESET_STATE: assert property (disable iff (1'b0)
		reset |=> pass_out && high_during_config && !low_during_config_n
		&& !config_done && init_oe) else $error("reset state wrong");
	AST_PROG_INIT: assert property (
		!$past(program_n, 2) && !$past(reset, 2) |-> init_oe)
		else $error("init not driven while program low");
	AST_DONE_EXCL: assert property (
		high_during_config || !low_during_config_n |-> !config_done)
		else $error("done while status shows config");
	AST_INIT_RELEASE: assert property (
		$fell(init_oe) |-> $past(init_oe, NUM_FRAMES))
		else $error("init released before a full pass");
	// the pin passes two sync flops, so the fall is seen two clocks late
	AST_PASS_ON_FALL: assert property (
		!$past(reset) && $changed(pass_out) && !config_clock_oe
		|-> !$past(config_clock_in, 2)) else $error("pass_out moved off fall");
	AST_CONFIG_CLOCK_HIGH: assert property (
		$rose(config_clock_out) |-> config_clock_out [*8])
		else $error("config clock high phase short");
	AST_CONFIG_CLOCK_LOW: assert property (
		$fell(config_clock_out) |-> !config_clock_out [*8])
		else $error("config clock low phase short");
	AST_ADDR_STEP: assert property (
		!$past(reset) && $changed(memory_address)
		|-> memory_address == $past(memory_address) + 1'b1 && config_clock_oe)
		else $error("address did not step by one");
	AST_BUF_HOLD: assert property (
		frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
		else $error("stalled frame bit lost");
	AST_DONE_HOLD: assert property (
		config_done && program_n && $past(program_n) |=> config_done)
		else $error("done dropped without program");
	cover property (frame_valid && frame_ready);
	cover property ($rose(config_done));
	cover property ($fell(init_oe));
	cover property ($changed(memory_address));
endmodule

/* testbench/fbcl_source.sv */
`timescale 1ns/100ps
// ==========================================
// far side: serial source and byte-wide memory
module fbcl_source (
	input logic init_in,
	input logic [17:0] memory_address,
	output logic config_clock_in,
	output logic serial_in,
	output logic [7:0] byte_in
);
	logic [7:0] mem [0:3] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};
	initial begin
		config_clock_in = 1'b0;
		serial_in = 1'b1;
	end
	assign byte_in = mem[memory_address[1:0]];
	// link clock only runs inside a bit; data set half a period ahead
	task automatic tick(input logic b);
		serial_in = b;
		#40;
		config_clock_in = 1'b1;
		#40;
		config_clock_in = 1'b0;
	endtask
	// odd offset keeps the link clock off the system clock phase
	task wait_ready;
		wait (init_in === 1'b1);
		#403;
	endtask
endmodule

/* testbench/test_fbcl_loader.sv */
`timescale 1ns/100ps
`include "fbcl_defs.vh"
`define FBCL_CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	n_fail++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
// ==========================================
// bench for the configuration loader
module test_fbcl_loader;
	localparam int NB = 47;
	localparam int INIT_WAIT = 10;
	localparam [3:0] PRE = `FBCL_PREAMBLE;
	localparam [23:0] LEN = 24'h00002F;
	localparam [9:0] FD = 10'h2D6;
	localparam [7:0] BYTE0 = 8'hA5;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic program_n = 1'b1;
	logic hold_init = 1'b0;
	logic frame_ready = 1'b0;
	logic [2:0] mode_lines = `FBCL_MODE_SLAVE_SERIAL;
	wire init_in, init_oe, config_clock_in, config_clock_out, config_clock_oe;
	wire serial_in, pass_out, high_during_config, low_during_config_n;
	wire config_done, config_overrun, frame_valid, frame_data;
	wire [7:0] byte_in;
	wire [17:0] memory_address;
	logic row_in [0:NB-1];
	logic row_exp [0:NB-1];
	logic want [$];
	logic got [$];
	logic prev;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	int i, k, n;
	// open drain: wire low if either party pulls
	assign init_in = ~(init_oe | hold_init);
	fbcl_loader #(.POR_CYCLES(20), .INIT_WAIT(INIT_WAIT), .FRAME_BITS(4),
		.FRAME_COUNT(2)) uut (
		.clock(clock), .reset(reset), .clock_enable(1'b1),
		.program_n(program_n), .init_in(init_in), .init_out(),
		.init_oe(init_oe), .mode_lines(mode_lines),
		.config_clock_in(config_clock_in), .config_clock_out(config_clock_out),
		.config_clock_oe(config_clock_oe), .serial_in(serial_in),
		.byte_in(byte_in), .memory_address(memory_address),
		.pass_out(pass_out), .high_during_config(high_during_config),
		.low_during_config_n(low_during_config_n), .config_done(config_done),
		.config_overrun(config_overrun), .frame_valid(frame_valid),
		.frame_ready(frame_ready), .frame_data(frame_data));
	fbcl_source src (.init_in(init_in), .memory_address(memory_address),
		.config_clock_in(config_clock_in), .serial_in(serial_in),
		.byte_in(byte_in));
	initial begin
		forever #5 clock = ~clock;
	end
	// sink stalls every other cycle
	always @(negedge clock) frame_ready <= ~frame_ready;
	always @(posedge clock) begin
		if (frame_valid === 1'b1 && frame_ready === 1'b1)
			got.push_back(frame_data);
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			$display("[ERR] run timed out");
			tally_and_finish();
		end
	end
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		for (i = 0; i < NB; i++) begin
			k = (i + 3) % 5;
			if (i < 4) row_in[i] = 1'b1;
			else if (i < 8) row_in[i] = PRE[7 - i];
			else if (i < 32) row_in[i] = LEN[31 - i];
			else if (i < 42) row_in[i] = (k == 0) ? 1'b0 : FD[i - 32];
			else row_in[i] = (k == 0) ? 1'b0 : ~k[0];
			row_exp[i] = (i >= 32 && i < 42) ? 1'b1 : row_in[i];
			if (i >= 32 && i < 42 && k != 0) want.push_back(row_in[i]);
		end
		repeat (4) @(negedge clock);
		reset = 1'b0;
		`FBCL_CHK("high_during_config", 1'b1, high_during_config);
		`FBCL_CHK("low_during_config_n", 1'b0, low_during_config_n);
		`FBCL_CHK("init_oe", 1'b1, init_oe);
		$display("test reset finished");
		src.wait_ready();
		prev = 1'b1;
		for (i = 0; i < NB; i++) begin
			src.tick(row_in[i]);
			`FBCL_CHK("pass_out", prev, pass_out);
			prev = row_exp[i];
		end
		#60;
		`FBCL_CHK("pass_out", prev, pass_out);
		`FBCL_CHK("frame bits", want.size(), got.size());
		foreach (want[j]) `FBCL_CHK("frame bit", want[j], got[j]);
		$display("test stream finished");
		n = 0;
		@(negedge clock);
		while (config_done !== 1'b1 && n < 50) begin
			@(negedge clock);
			n++;
		end
		`FBCL_CHK("config_done", 1'b1, config_done);
		`FBCL_CHK("high_during_config", 1'b0, high_during_config);
		`FBCL_CHK("low_during_config_n", 1'b1, low_during_config_n);
		`FBCL_CHK("config_overrun", 1'b0, config_overrun);
		$display("test startup finished");
		program_n = 1'b0;
		hold_init = 1'b1;
		repeat (3) @(negedge clock);
		`FBCL_CHK("init_oe", 1'b1, init_oe);
		`FBCL_CHK("config_done", 1'b0, config_done);
		repeat (20) @(negedge clock);
		program_n = 1'b1;
		mode_lines = `FBCL_MODE_MASTER_PAR;
		repeat (150) @(negedge clock);
		`FBCL_CHK("init_oe", 1'b0, init_oe);
		`FBCL_CHK("config_clock_oe", 1'b0, config_clock_oe);
		hold_init = 1'b0;
		n = 0;
		while (config_clock_oe !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		`FBCL_CHK("init wait", 1'b1, n >= INIT_WAIT + 2);
		`FBCL_CHK("config_clock_oe", 1'b1, config_clock_oe);
		$display("test program finished");
		n = 0;
		while (config_clock_out !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		repeat (3) @(negedge clock);
		`FBCL_CHK("memory_address", 18'h00001, memory_address);
		for (k = 1; k < 10; k++) begin
			@(negedge config_clock_out);
			repeat (3) @(negedge clock);
			if (k >= 2) `FBCL_CHK("pass_out", BYTE0[k - 2], pass_out);
		end
		`FBCL_CHK("memory_address", 18'h00002, memory_address);
		$display("test master finished");
		tally_and_finish();
	end
endmodule
bind fbcl_loader fbcl_loader_props #(.NUM_FRAMES(NUM_FRAMES),
	.ADDR_WIDTH(ADDR_WIDTH)) u_props (.clock(clock), .reset(reset),
	.program_n(program_n), .init_oe(init_oe),
	.config_clock_in(config_clock_in), .config_clock_out(config_clock_out),
	.config_clock_oe(config_clock_oe), .memory_address(memory_address),
	.pass_out(pass_out), .high_during_config(high_during_config),
	.low_during_config_n(low_during_config_n), .config_done(config_done),
	.frame_valid(frame_valid), .frame_ready(frame_ready),
	.frame_data(frame_data));
